/* rtl/mxc_max_addr_cmds.sv */
`timescale 1ns/100ps
`default_nettype none
module mxc_max_addr_cmds (
    input  wire logic        i_clk_sys,        // system clock
    input  wire logic        i_rstn,           // async reset, active low
    input  wire logic        i_cmd_valid,      // one-cycle command strobe
    input  wire logic [7:0]  i_cmd_code,       // command register
    input  wire logic [7:0]  i_count_cur,      // sector count current
    input  wire logic [7:0]  i_secnum_cur,     // sector number current
    input  wire logic [7:0]  i_secnum_prev,    // sector number previous
    input  wire logic [7:0]  i_cyl_lo_cur,     // cylinder low current
    input  wire logic [7:0]  i_cyl_lo_prev,    // cylinder low previous
    input  wire logic [7:0]  i_cyl_hi_cur,     // cylinder high current
    input  wire logic [7:0]  i_cyl_hi_prev,    // cylinder high previous
    input  wire logic        i_high_byte_readback_select, // readback half
    input  wire logic        i_ext_supported,  // 37h implemented
    input  wire logic [47:0] i_native_max,     // real capacity max address
    input  wire logic        i_hpa_set_28,     // area set by 28-bit command
    input  wire logic        i_max_locked,     // locked state
    input  wire logic        i_max_frozen,     // frozen state
    input  wire logic        i_offset_mode,    // address offset mode
    input  wire logic        i_hard_reset,     // hardware reset pulse
    input  wire logic        i_acc_valid,      // media access request pulse
    input  wire logic [47:0] i_acc_lba,        // media access address
    output logic             o_acc_abort,      // access refused pulse
    output logic             o_done,           // command complete pulse
    output logic [7:0]       o_status,         // status register
    output logic [7:0]       o_error,          // error register
    output logic [7:0]       o_secnum,         // readback sector number
    output logic [7:0]       o_cyl_lo,         // readback cylinder low
    output logic [7:0]       o_cyl_hi,         // readback cylinder high
    output logic [47:0]      o_max_lba,        // current max address
    output logic             o_max_persist,    // max held across hard reset
    output logic [47:0]      o_id_words_48,    // capacity words 103:100
    output logic [27:0]      o_id_words_28,    // capacity words 61:60
    output logic             o_multi_enable,   // multi-sector enabled
    output logic [7:0]       o_block_size      // sectors per interrupt
);

    typedef struct packed {
        logic        prev_native;
        logic        nv_done;
        logic [47:0] max_lba;
        logic        persist;
        logic [47:0] id48;
        logic [27:0] id28;
        logic        multi_en;
        logic [7:0]  blk;
        logic [7:0]  status;
        logic [7:0]  error;
        logic        done;
        logic        acc_abort;
    } mxc_state_s;

    mxc_state_s  st_q;
    mxc_state_s  st_d;
    logic [47:0] req_lba;
    logic        req_over;
    logic        acc_over;
    logic        blk_ok;
    logic        ext_abort;
    logic        is_ext;
    logic        is_mult;
    logic        ext_take;

    // current bytes low, previous bytes high
    assign req_lba = {i_cyl_hi_prev, i_cyl_lo_prev, i_secnum_prev,
                      i_cyl_hi_cur, i_cyl_lo_cur, i_secnum_cur};

    mxc_range_check u_req_range (
        .i_lba   (req_lba),
        .i_limit (i_native_max),
        .o_above (req_over)
    );

    mxc_range_check u_acc_range (
        .i_lba   (i_acc_lba),
        .i_limit (st_q.max_lba),
        .o_above (acc_over)
    );

    mxc_blk_check u_blk (
        .i_count (i_count_cur),
        .o_valid (blk_ok)
    );

    assign is_ext  = i_cmd_valid && (i_cmd_code == mxc_pkg::CMD_SET_MAX_EXT);
    assign is_mult = i_cmd_valid && (i_cmd_code == mxc_pkg::CMD_SET_MULTIPLE);
    assign ext_take = is_ext && !ext_abort;

    always_comb begin
        ext_abort = !i_ext_supported || req_over || i_hpa_set_28;
        ext_abort = ext_abort || !st_q.prev_native;
        ext_abort = ext_abort || i_max_locked || i_max_frozen;
        if (i_count_cur[mxc_pkg::PERSIST_BIT]) begin
            ext_abort = ext_abort || st_q.nv_done || i_offset_mode;
        end
    end

    always_comb begin
        st_d           = st_q;
        st_d.done      = 1'b0;
        st_d.acc_abort = 1'b0;
        if (i_cmd_valid) begin
            // any command other than native read breaks the pairing
            st_d.prev_native = (i_cmd_code == mxc_pkg::CMD_READ_NATIVE_X);
            st_d.done        = is_ext || is_mult;
        end
        if (is_ext) begin
            if (ext_abort) begin
                st_d.error = 8'h00;
                st_d.error[mxc_pkg::ER_ABORT_BIT] = 1'b1;
                st_d.status = mxc_pkg::STATUS_RST;
                st_d.status[mxc_pkg::ST_ERR_BIT] = 1'b1;
            end else begin
                st_d.max_lba = req_lba;
                st_d.persist = i_count_cur[mxc_pkg::PERSIST_BIT];
                st_d.nv_done = st_q.nv_done || i_count_cur[mxc_pkg::PERSIST_BIT];
                st_d.id48    = req_lba;
                if (req_lba <= mxc_pkg::LBA28_LIMIT) begin
                    st_d.id28 = req_lba[27:0];
                end
                st_d.error  = 8'h00;
                st_d.status = mxc_pkg::STATUS_RST;
            end
        end
        if (is_mult) begin
            if (blk_ok) begin
                st_d.blk      = i_count_cur;
                st_d.multi_en = (i_count_cur != 8'h00);
                st_d.error    = 8'h00;
                st_d.status   = mxc_pkg::STATUS_RST;
            end else begin
                st_d.multi_en = 1'b0;
                st_d.blk      = 8'h00;
                st_d.error    = 8'h00;
                st_d.error[mxc_pkg::ER_ABORT_BIT] = 1'b1;
                st_d.status = mxc_pkg::STATUS_RST;
                st_d.status[mxc_pkg::ST_ERR_BIT] = 1'b1;
            end
        end
        if (i_acc_valid && acc_over) begin
            st_d.acc_abort = 1'b1;
            st_d.error     = 8'h00;
            st_d.error[mxc_pkg::ER_ABORT_BIT] = 1'b1;
            st_d.status    = mxc_pkg::STATUS_RST;
            st_d.status[mxc_pkg::ST_ERR_BIT] = 1'b1;
        end
        if (i_hard_reset) begin
            // a set accepted in the same cycle outlives the reset
            st_d.nv_done  = ext_take && i_count_cur[mxc_pkg::PERSIST_BIT];
            st_d.multi_en = 1'b0;
            st_d.blk      = mxc_pkg::BLK_SIZE_RST;
            if (!st_q.persist && !ext_take) begin
                st_d.max_lba = i_native_max;
                st_d.id48    = i_native_max;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q.prev_native <= 1'b0;
            st_q.nv_done     <= 1'b0;
            st_q.max_lba     <= mxc_pkg::NATIVE_MAX_RST;
            st_q.persist     <= 1'b0;
            st_q.id48        <= mxc_pkg::NATIVE_MAX_RST;
            st_q.id28        <= mxc_pkg::LBA28_LIMIT[27:0];
            st_q.multi_en    <= 1'b0;
            st_q.blk         <= mxc_pkg::BLK_SIZE_RST;
            st_q.status      <= mxc_pkg::STATUS_RST;
            st_q.error       <= 8'h00;
            st_q.done        <= 1'b0;
            st_q.acc_abort   <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // readback halves chosen by select
    always_comb begin
        if (i_high_byte_readback_select) begin
            o_secnum = st_q.max_lba[31:24];
            o_cyl_lo = st_q.max_lba[39:32];
            o_cyl_hi = st_q.max_lba[47:40];
        end else begin
            o_secnum = st_q.max_lba[7:0];
            o_cyl_lo = st_q.max_lba[15:8];
            o_cyl_hi = st_q.max_lba[23:16];
        end
    end

    assign o_acc_abort    = st_q.acc_abort;
    assign o_done         = st_q.done;
    assign o_status       = st_q.status;
    assign o_error        = st_q.error;
    assign o_max_lba      = st_q.max_lba;
    assign o_max_persist  = st_q.persist;
    assign o_id_words_48  = st_q.id48;
    assign o_id_words_28  = st_q.id28;
    assign o_multi_enable = st_q.multi_en;
    assign o_block_size   = st_q.blk;

    property p_ext_pair;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (is_ext && !st_q.prev_native) |=> o_error[mxc_pkg::ER_ABORT_BIT];
    endproperty
    a_ext_pair: assert property (p_ext_pair) else $error("unpaired set not aborted");

    property p_acc_abort;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_acc_valid && (i_acc_lba > st_q.max_lba)) |=> o_acc_abort;
    endproperty
    a_acc_abort: assert property (p_acc_abort) else $error("access above max kept");

    property p_id28_keep;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (is_ext && !ext_abort && req_lba > mxc_pkg::LBA28_LIMIT)
            |=> (o_id_words_28 == $past(o_id_words_28)) && (o_id_words_48 == $past(req_lba));
    endproperty
    a_id28_keep: assert property (p_id28_keep) else $error("28-bit words changed");

    property p_frozen;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (is_ext && i_max_frozen) |=> (o_max_lba == $past(o_max_lba)) && o_status[0];
    endproperty
    a_frozen: assert property (p_frozen) else $error("frozen set accepted");

    property p_nv_twice;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (is_ext && st_q.nv_done && i_count_cur[0]) |=> o_error[mxc_pkg::ER_ABORT_BIT];
    endproperty
    a_nv_twice: assert property (p_nv_twice) else $error("second persistent set taken");

    property p_blk_bad;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (is_mult && !blk_ok) |=> !o_multi_enable && o_error[mxc_pkg::ER_ABORT_BIT];
    endproperty
    a_blk_bad: assert property (p_blk_bad) else $error("bad size not aborted");

    property p_blk_zero;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (is_mult && i_count_cur == 8'h00) |=> !o_multi_enable;
    endproperty
    a_blk_zero: assert property (p_blk_zero) else $error("zero size enabled");

    property p_abort_status;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (o_done && o_error[mxc_pkg::ER_ABORT_BIT])
            |-> o_status[0] && !o_status[7] && !o_status[5] && !o_status[2];
    endproperty
    a_abort_status: assert property (p_abort_status) else $error("abort status wrong");

    property p_ext_take;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (ext_take && !i_hard_reset) |=> o_done && (o_max_lba == $past(req_lba));
    endproperty
    a_ext_take: assert property (p_ext_take) else $error("set not applied");

    property p_id28_update;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (ext_take && !i_hard_reset && req_lba <= mxc_pkg::LBA28_LIMIT)
            |=> (o_id_words_28 == $past(req_lba[27:0])) && (o_id_words_48 == $past(req_lba));
    endproperty
    a_id28_update: assert property (p_id28_update) else $error("id28 stale");

    property p_persist_sel;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (ext_take && !i_hard_reset)
            |=> o_max_persist == $past(i_count_cur[mxc_pkg::PERSIST_BIT]);
    endproperty
    a_persist_sel: assert property (p_persist_sel) else $error("persist wrong");

    property p_over_cap;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (is_ext && (!i_ext_supported || req_over || i_hpa_set_28))
            |=> o_error[mxc_pkg::ER_ABORT_BIT] && o_status[mxc_pkg::ST_ERR_BIT];
    endproperty
    a_over_cap: assert property (p_over_cap) else $error("bad set taken");

    property p_locked;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (is_ext && i_max_locked && !i_hard_reset)
            |=> $stable(o_max_lba) && o_error[mxc_pkg::ER_ABORT_BIT];
    endproperty
    a_locked: assert property (p_locked) else $error("locked set taken");

    property p_offset_nv;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (is_ext && i_offset_mode && i_count_cur[mxc_pkg::PERSIST_BIT] && !i_hard_reset)
            |=> $stable(o_max_lba) && o_error[mxc_pkg::ER_ABORT_BIT];
    endproperty
    a_offset_nv: assert property (p_offset_nv) else $error("offset keep taken");

    property p_nv_clear;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_hard_reset && !ext_take) |=> !st_q.nv_done;
    endproperty
    a_nv_clear: assert property (p_nv_clear) else $error("once flag kept");

    property p_acc_quiet;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !(i_acc_valid && acc_over) |=> !o_acc_abort;
    endproperty
    a_acc_quiet: assert property (p_acc_quiet) else $error("access wrongly refused");

    property p_done_pulse;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !(is_ext || is_mult) |=> !o_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("stray done");

    property p_blk_take;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (is_mult && blk_ok && !i_hard_reset) |=> (o_block_size == $past(i_count_cur))
            && (o_multi_enable == ($past(i_count_cur) != 8'h00));
    endproperty
    a_blk_take: assert property (p_blk_take) else $error("size not taken");

    property p_blk_hold;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (!is_mult && !i_hard_reset) |=> $stable(o_block_size) && $stable(o_multi_enable);
    endproperty
    a_blk_hold: assert property (p_blk_hold) else $error("size lost");

    property p_ext_refuse;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (is_ext && ext_abort && !i_hard_reset)
            |=> $stable(o_max_lba) && $stable(o_id_words_48) && $stable(o_max_persist);
    endproperty
    a_ext_refuse: assert property (p_ext_refuse) else $error("refused set applied");

endmodule : mxc_max_addr_cmds
`default_nettype wire

/* rtl/mxc_pkg.sv */
package mxc_pkg;
    localparam logic [7:0]  CMD_SET_MAX_EXT   = 8'h37;
    localparam logic [7:0]  CMD_SET_MULTIPLE  = 8'hC6;
    localparam logic [7:0]  CMD_READ_NATIVE_X = 8'h27;
    localparam logic [47:0] LBA28_LIMIT       = 48'h00000FFFFFFF;
    localparam logic [47:0] NATIVE_MAX_RST    = 48'h0000FFFFFFFF;
    localparam logic [7:0]  BLK_SIZE_RST      = 8'h00;
    localparam int          PERSIST_BIT       = 0;
    // status and error bit positions
    localparam int          ST_BUSY_BIT       = 7;
    localparam int          ST_READY_BIT      = 6;
    localparam int          ST_FAULT_BIT      = 5;
    localparam int          ST_CORR_BIT       = 2;
    localparam int          ST_ERR_BIT        = 0;
    localparam int          ER_ABORT_BIT      = 2;
    localparam logic [7:0]  STATUS_RST        = 8'h40;
endpackage : mxc_pkg

/* rtl/mxc_blk_check.sv */
`timescale 1ns/100ps
`default_nettype none
module mxc_blk_check (
    input  wire logic [7:0] i_count,  // requested block size
    output logic            o_valid   // size is one of 0,1,2,4,8,16
);
    always_comb begin
        unique case (i_count)
            8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10: o_valid = 1'b1;
            default:                                   o_valid = 1'b0;
        endcase
    end
endmodule : mxc_blk_check
`default_nettype wire

/* rtl/mxc_range_check.sv */
`timescale 1ns/100ps
`default_nettype none
module mxc_range_check (
    input  wire logic [47:0] i_lba,    // address under test
    input  wire logic [47:0] i_limit,  // highest permitted address
    output logic             o_above   // address exceeds limit
);
    assign o_above = (i_lba > i_limit);
endmodule : mxc_range_check
`default_nettype wire

/* verification/mxc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// host controller writing the task file one command at a time
module mxc_host_model (
    input  wire logic       i_clk_sys,     // system clock
    output var  logic       o_cmd_valid,   // command strobe
    output var  logic [7:0] o_cmd_code,    // command code
    output var  logic [7:0] o_count_cur,   // sector count
    output var  logic [7:0] o_secnum_cur,  // address 7:0
    output var  logic [7:0] o_secnum_prev, // address 31:24
    output var  logic [7:0] o_cyl_lo_cur,  // address 15:8
    output var  logic [7:0] o_cyl_lo_prev, // address 39:32
    output var  logic [7:0] o_cyl_hi_cur,  // address 23:16
    output var  logic [7:0] o_cyl_hi_prev  // address 47:40
);
    initial begin
        o_cmd_valid = 1'b0;
        {o_cmd_code, o_count_cur, o_secnum_cur, o_secnum_prev} = '0;
        {o_cyl_lo_cur, o_cyl_lo_prev, o_cyl_hi_cur, o_cyl_hi_prev} = '0;
    end
    task automatic put(input logic [7:0] c, input logic [7:0] n, input logic [47:0] a);
        o_cmd_code  <= c;
        o_count_cur <= n;
        {o_cyl_hi_prev, o_cyl_lo_prev, o_secnum_prev} <= a[47:24];
        {o_cyl_hi_cur, o_cyl_lo_cur, o_secnum_cur}    <= a[23:0];
    endtask : put
    // idle lines carry the inverse so a stale value never looks valid
    task automatic send(input logic [7:0] c, input logic [7:0] n, input logic [47:0] a);
        @(posedge i_clk_sys);
        o_cmd_valid <= 1'b1;
        put(c, n, a);
        @(posedge i_clk_sys);
        o_cmd_valid <= 1'b0;
        put(~c, ~n, ~a);
    endtask : send
    // unpaired or keep in offset mode only when a scenario asks for a refusal
    task automatic set_max(input logic [47:0] a, input logic keep, input logic paired);
        if (paired) send(mxc_pkg::CMD_READ_NATIVE_X, 8'h00, '0);
        send(mxc_pkg::CMD_SET_MAX_EXT, {7'h00, keep}, a);
    endtask : set_max
endmodule : mxc_host_model
`default_nettype wire

/* verification/test_mxc_max_addr_cmds.sv */
`timescale 1ns/100ps
`default_nettype none
module test_mxc_max_addr_cmds;
    localparam logic [47:0] NATIVE = 48'h00FFFFFFFFFF;
    logic        clk, rstn, vld, high_byte_readback_select, sup, hpa, lck, frz, ofs, hrst, acc, aab, done, pers, men;
    logic [7:0]  code, cnt, sn_c, sn_p, cl_c, cl_p, ch_c, ch_p, st, er, sn_o, cl_o, ch_o, bsz;
    logic [7:0]  v, e;
    logic [47:0] alba, mx, id48, a, b;
    logic [27:0] id28;
    int          miscompares, checks, i;

    mxc_host_model host_u (.i_clk_sys(clk), .o_cmd_valid(vld), .o_cmd_code(code),
        .o_count_cur(cnt), .o_secnum_cur(sn_c), .o_secnum_prev(sn_p), .o_cyl_lo_cur(cl_c),
        .o_cyl_lo_prev(cl_p), .o_cyl_hi_cur(ch_c), .o_cyl_hi_prev(ch_p));
    mxc_max_addr_cmds dut_u (.i_clk_sys(clk), .i_rstn(rstn), .i_cmd_valid(vld),
        .i_cmd_code(code), .i_count_cur(cnt), .i_secnum_cur(sn_c), .i_secnum_prev(sn_p),
        .i_cyl_lo_cur(cl_c), .i_cyl_lo_prev(cl_p), .i_cyl_hi_cur(ch_c), .i_cyl_hi_prev(ch_p),
        .i_high_byte_readback_select(high_byte_readback_select), .i_ext_supported(sup), .i_native_max(NATIVE),
        .i_hpa_set_28(hpa), .i_max_locked(lck), .i_max_frozen(frz), .i_offset_mode(ofs),
        .i_hard_reset(hrst), .i_acc_valid(acc), .i_acc_lba(alba), .o_acc_abort(aab),
        .o_done(done), .o_status(st), .o_error(er), .o_secnum(sn_o), .o_cyl_lo(cl_o),
        .o_cyl_hi(ch_o), .o_max_lba(mx), .o_max_persist(pers), .o_id_words_48(id48),
        .o_id_words_28(id28), .o_multi_enable(men), .o_block_size(bsz));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_of_test;
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [47:0] x, input logic [47:0] g);
        checks++;
        if (g !== x) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // outputs of the taking edge are settled one step later
    task automatic res(input logic ab);
        #1;
        chk("done", 1'b1, done);
        chk("status", ab ? 8'h41 : 8'h40, st);
        chk("error", ab ? 8'h04 : 8'h00, er);
    endtask : res
    task automatic access(input logic [47:0] l, input logic ab);
        @(posedge clk);
        acc  <= 1'b1;
        alba <= l;
        @(posedge clk);
        acc  <= 1'b0;
        alba <= ~l;
        #1;
        chk("acc_abort", ab, aab);
    endtask : access
    task automatic rb(input logic h, input logic [23:0] x);
        @(posedge clk);
        high_byte_readback_select <= h;
        #1;
        chk("readback", x, {ch_o, cl_o, sn_o});
    endtask : rb
    task automatic lv(input logic [4:0] m);
        @(posedge clk);
        {sup, hpa, lck, frz, ofs} <= m;
    endtask : lv
    task automatic hard_rst;
        @(posedge clk);
        hrst <= 1'b1;
        @(posedge clk);
        hrst <= 1'b0;
        #1;
    endtask : hard_rst
    function automatic logic [7:0] exp_size(input logic [7:0] s);
        return (s inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10}) ? s : 8'h00;
    endfunction : exp_size

    initial begin
        rstn = 1'b0;
        {high_byte_readback_select, hrst, acc, alba} = '0;
        {sup, hpa, lck, frz, ofs} = 5'b10000;
        miscompares = 0;
        checks = 0;
        i = $urandom(17606);
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("multi", 1'b0, men);
        a = {20'h00000, 28'($urandom)};
        b = mxc_pkg::LBA28_LIMIT + 48'h1 + 48'($urandom & 32'h0000FFFF);
        host_u.set_max(a, 1'b0, 1'b1);
        res(1'b0);
        chk("max", a, mx);
        chk("id28", a[27:0], id28);
        chk("persist", 1'b0, pers);
        rb(1'b0, a[23:0]);
        rb(1'b1, a[47:24]);
        access(a, 1'b0);
        access(a + 48'h1, 1'b1);
        chk("acc_error", 8'h04, er);
        host_u.set_max(b, 1'b0, 1'b1);
        res(1'b0);
        chk("id48", b, id48);
        chk("id28", a[27:0], id28);
        host_u.set_max(mxc_pkg::LBA28_LIMIT, 1'b0, 1'b1);
        res(1'b0);
        chk("id28", 28'hFFFFFFF, id28);
        host_u.send(mxc_pkg::CMD_SET_MULTIPLE, 8'h02, '0);
        res(1'b0);
        host_u.set_max(a, 1'b0, 1'b0);
        res(1'b1);
        for (i = 0; i < 6; i++) begin
            lv({i != 0, i == 2, i == 3, i == 4, i == 5});
            host_u.set_max((i == 1) ? NATIVE + 48'h1 : a, i == 5, 1'b1);
            res(1'b1);
            chk("max", mxc_pkg::LBA28_LIMIT, mx);
        end
        lv(5'b10000);
        host_u.set_max(a, 1'b1, 1'b1);
        res(1'b0);
        chk("persist", 1'b1, pers);
        host_u.set_max(b, 1'b1, 1'b1);
        res(1'b1);
        hard_rst();
        chk("max", a, mx);
        host_u.set_max(b, 1'b1, 1'b1);
        res(1'b0);
        rb(1'b1, b[47:24]);
        host_u.set_max(a, 1'b0, 1'b1);
        res(1'b0);
        hard_rst();
        chk("max", NATIVE, mx);
        chk("id48", NATIVE, id48);
        for (i = 0; i < 22; i++) begin
            v = (i < 18) ? 8'(i) : 8'($urandom);
            e = exp_size(v);
            host_u.send(mxc_pkg::CMD_SET_MULTIPLE, v, 48'($urandom));
            res(e !== v);
            chk("size", e, bsz);
            chk("multi", e != 8'h00, men);
        end
        host_u.send(mxc_pkg::CMD_SET_MULTIPLE, 8'h10, '0);
        host_u.send(mxc_pkg::CMD_READ_NATIVE_X, 8'h00, '0);
        access(48'h0, 1'b0);
        chk("size", 8'h10, bsz);
        end_of_test();
    end
    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_of_test();
    end
endmodule : test_mxc_max_addr_cmds
`default_nettype wire
